// file: logic/lcdc_consts.vh
// Register map, field positions, reset values and divider counts.
`ifndef LCDC_CONSTS_VH
`define LCDC_CONSTS_VH
// Register indices; a register sits at byte address index * 4.
`define LCDC_IDX_CTRL 16'h2021
`define LCDC_IDX_PSEL0 16'h2026
`define LCDC_IDX_PSEL1 16'h2027
`define LCDC_IDX_PSEL2 16'h2028
`define LCDC_IDX_BLINK 16'h205A
`define LCDC_IDX_DAC 16'h20AB
// Field positions.
`define LCDC_DIV_MSB 1
`define LCDC_DIV_LSB 0
`define LCDC_EN_BIT 5
`define LCDC_PSEL1_HI_MSB 7
`define LCDC_PSEL1_HI_LSB 5
`define LCDC_PSEL1_LO_MSB 3
`define LCDC_PSEL1_LO_LSB 0
`define LCDC_DAC_MSB 3
`define LCDC_DAC_LSB 1
// Reset values.
`define LCDC_RST_DIV 2'h0
`define LCDC_RST_EN 1'h0
`define LCDC_RST_PSEL0 3'h0
`define LCDC_RST_PSEL1 7'h00
`define LCDC_RST_PSEL2 8'h00
`define LCDC_RST_BLINK 4'h0
`define LCDC_RST_DAC 3'h0
// Frame divider codes and crystal ticks per frame-clock half period.
`define LCDC_DIV_CODE_512 2'h0
`define LCDC_DIV_CODE_256 2'h1
`define LCDC_DIV_CODE_128 2'h2
`define LCDC_DIV_CODE_64 2'h3
`define LCDC_HALF_512 9'h100
`define LCDC_HALF_256 9'h080
`define LCDC_HALF_128 9'h040
`define LCDC_HALF_64 9'h020
// Clock rates for the crystal tick generator.
`define LCDC_CLK_HZ 26'h17D_7840
`define LCDC_XTAL_HZ 26'h0_8000
`endif

// file: logic/lcdc_config.v
// LCD segment drive configuration: registers, pin muxing, frame divider.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ns
// Summary of operation
// - select bit 1 gives segment, 0 gives I/O
// - 2026 bits 2..0 select segments 48..50
// - 2027 bits 7..5 seg 63..61, 3..0 seg 59..56
// - 2028 bits select segments 64..71 ascending
// - blink mask bit n applies to common n
// - divider codes 01/10/11 give 256/128/64
// - contrast code goes to the voltage DAC
// - display disabled grounds rails, commons, segments
`include "lcdc_consts.vh"

module lcdc_config #(
	parameter NPIN = 18,
	parameter NCOM = 4,
	parameter [25:0] CLK_HZ = `LCDC_CLK_HZ,
	parameter [25:0] XTAL_HZ = `LCDC_XTAL_HZ
) (
	// Clock and reset.
	input wire clk,
	input wire rst,
	// Avalon-MM slave, byte addressed.
	input wire [15:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	output reg [31:0] readdata,
	output reg waitrequest,
	// Drive from the segment and common waveform generator.
	input wire [NPIN-1:0] seg_drive,
	input wire [NCOM-1:0] com_drive,
	// General-purpose I/O function of the shared pins.
	input wire [NPIN-1:0] general_io_out,
	input wire [NPIN-1:0] general_io_oe,
	output reg [NPIN-1:0] general_io_in,
	// Shared pads.
	input wire [NPIN-1:0] pin_in,
	output reg [NPIN-1:0] pin_out,
	output reg [NPIN-1:0] pin_oe,
	// Common outputs and bias rail enables.
	output reg [NCOM-1:0] com_out,
	output reg bias_rail_top,
	output reg bias_rail_mid,
	output reg bias_rail_low,
	// Frame timing, blink and contrast.
	output reg frame_clock,
	output reg frame_tick,
	output reg [1:0] com_slot,
	output reg blink_active,
	output reg [2:0] contrast_code,
	output reg display_enable
);

	// Configuration registers.
	reg [1:0] frame_clock_divider;
	reg [2:0] pin_select_seg48_50;
	reg [6:0] pin_select_seg56_63;
	reg [7:0] pin_select_seg64_71;
	reg [3:0] blink_mask_seg18;

	// Byte addresses of the registers. Each register sits at four times
	// its index on the byte-addressed bus, and the top two index bits
	// fall off the 16-bit address on purpose; no index here needs them.
	localparam [15:0] ADDR_CTRL = `LCDC_IDX_CTRL << 2;
	localparam [15:0] ADDR_PSEL0 = `LCDC_IDX_PSEL0 << 2;
	localparam [15:0] ADDR_PSEL1 = `LCDC_IDX_PSEL1 << 2;
	localparam [15:0] ADDR_PSEL2 = `LCDC_IDX_PSEL2 << 2;
	localparam [15:0] ADDR_BLINK = `LCDC_IDX_BLINK << 2;
	localparam [15:0] ADDR_DAC = `LCDC_IDX_DAC << 2;

	// Only full-word accesses are decoded. Byte enables are not part of
	// this port, so a write always replaces every field of a register.
	// Software that wants to change one field must read, merge and write.

	// Bus handshake.
	wire req = read | write;
	wire wr_fire = write & ~waitrequest;

	// Every request is answered one edge after it appears, then the
	// slave returns to waiting so back-to-back requests each get one wait.
	// The fixed single wait keeps the answer time independent of the
	// address, at the cost of one cycle per access that a faster slave
	// could have saved. A master must not raise read and write together.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			waitrequest <= 1'b1;
		end else if (req && waitrequest) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// Read data path; unmapped addresses read as zero.
	// Bits that belong to no field read as zero as well, so software can
	// compare a read-back word against what it meant to store.
	reg [31:0] next_readdata;
	always @* begin
		next_readdata = 32'h0000_0000;
		case (address)
		ADDR_CTRL: begin
			next_readdata[`LCDC_DIV_MSB:`LCDC_DIV_LSB] = frame_clock_divider;
			next_readdata[`LCDC_EN_BIT] = display_enable;
		end
		ADDR_PSEL0: begin
			next_readdata[2:0] = pin_select_seg48_50;
		end
		ADDR_PSEL1: begin
			next_readdata[`LCDC_PSEL1_HI_MSB:`LCDC_PSEL1_HI_LSB] =
				pin_select_seg56_63[6:4];
			next_readdata[`LCDC_PSEL1_LO_MSB:`LCDC_PSEL1_LO_LSB] =
				pin_select_seg56_63[3:0];
		end
		ADDR_PSEL2: begin
			next_readdata[7:0] = pin_select_seg64_71;
		end
		ADDR_BLINK: begin
			next_readdata[3:0] = blink_mask_seg18;
		end
		ADDR_DAC: begin
			next_readdata[`LCDC_DAC_MSB:`LCDC_DAC_LSB] = contrast_code;
		end
		default: begin
			next_readdata = 32'h0000_0000;
		end
		endcase
	end

	// The read word is captured on the edge that takes the request, so it
	// stands at the following edge, where waitrequest is low.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			readdata <= 32'h0000_0000;
		end else if (read && waitrequest) begin
			readdata <= next_readdata;
		end
	end

	// Register writes take effect at the edge where waitrequest is low.
	// A write to an unmapped address is taken with the same timing and
	// changes nothing, so a stray access cannot stall the bus.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			frame_clock_divider <= `LCDC_RST_DIV;
			display_enable <= `LCDC_RST_EN;
			pin_select_seg48_50 <= `LCDC_RST_PSEL0;
			pin_select_seg56_63 <= `LCDC_RST_PSEL1;
			pin_select_seg64_71 <= `LCDC_RST_PSEL2;
			blink_mask_seg18 <= `LCDC_RST_BLINK;
			contrast_code <= `LCDC_RST_DAC;
		end else if (wr_fire) begin
			case (address)
			ADDR_CTRL: begin
				frame_clock_divider <=
					writedata[`LCDC_DIV_MSB:`LCDC_DIV_LSB];
				display_enable <= writedata[`LCDC_EN_BIT];
			end
			ADDR_PSEL0: begin
				pin_select_seg48_50 <= writedata[2:0];
			end
			ADDR_PSEL1: begin
				// Bit 4 has no pin behind it and is dropped.
				pin_select_seg56_63 <= {
					writedata[`LCDC_PSEL1_HI_MSB:`LCDC_PSEL1_HI_LSB],
					writedata[`LCDC_PSEL1_LO_MSB:`LCDC_PSEL1_LO_LSB]
				};
			end
			ADDR_PSEL2: begin
				pin_select_seg64_71 <= writedata[7:0];
			end
			ADDR_BLINK: begin
				blink_mask_seg18 <= writedata[3:0];
			end
			ADDR_DAC: begin
				contrast_code <= writedata[`LCDC_DAC_MSB:`LCDC_DAC_LSB];
			end
			default: begin
				display_enable <= display_enable;
			end
			endcase
		end
	end

	// Pin select vector: index 0..2 seg48..50, 3..6 seg56..59,
	// 7..9 seg61..63, 10..17 seg64..71.
	wire [NPIN-1:0] pin_select = {
		pin_select_seg64_71,
		pin_select_seg56_63,
		pin_select_seg48_50
	};

	// Per-pin routing between segment drive and general I/O.
	// The pad drive is registered, so a change of select reaches the pad
	// one cycle later. A pin handed to the segment driver is always
	// driven; its general I/O input reads zero so that firmware polling a
	// pin it gave away sees a steady value rather than the segment wave.
	genvar i;
	generate
		for (i = 0; i < NPIN; i = i + 1) begin : g_pin
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					pin_out[i] <= 1'b0;
					pin_oe[i] <= 1'b0;
					general_io_in[i] <= 1'b0;
				end else if (pin_select[i]) begin
					// A disabled display still drives its pins, at ground.
					pin_out[i] <= seg_drive[i] & display_enable;
					pin_oe[i] <= 1'b1;
					general_io_in[i] <= 1'b0;
				end else begin
					pin_out[i] <= general_io_out[i];
					pin_oe[i] <= general_io_oe[i];
					general_io_in[i] <= pin_in[i];
				end
			end
		end
	endgenerate

	// Commons and bias rails follow the display enable.
	// The rail outputs are enables for the analogue bias stage; a zero
	// there means the rail is pulled to ground, not left floating.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			com_out <= {NCOM{1'b0}};
			bias_rail_top <= 1'b0;
			bias_rail_mid <= 1'b0;
			bias_rail_low <= 1'b0;
		end else begin
			com_out <= com_drive & {NCOM{display_enable}};
			bias_rail_top <= display_enable;
			bias_rail_mid <= display_enable;
			bias_rail_low <= display_enable;
		end
	end

	// Crystal-rate enable made from the system clock by a fractional
	// accumulator; average rate is exact, jitter is one system clock.
	// This avoids a second clock domain for the crystal rate. The limit
	// is that XTAL_HZ must stay below CLK_HZ, or ticks would be lost.
	reg [25:0] xtal_acc;
	reg xtal_tick;
	wire [26:0] acc_sum = {1'b0, xtal_acc} + {1'b0, XTAL_HZ};
	wire acc_wrap = acc_sum >= {1'b0, CLK_HZ};
	wire [26:0] acc_left = acc_sum - {1'b0, CLK_HZ};

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			xtal_acc <= 26'h000_0000;
			xtal_tick <= 1'b0;
		end else if (acc_wrap) begin
			xtal_acc <= acc_left[25:0];
			xtal_tick <= 1'b1;
		end else begin
			xtal_acc <= acc_sum[25:0];
			xtal_tick <= 1'b0;
		end
	end

	// Half-period count of the frame clock in crystal ticks.
	reg [8:0] half_count;
	always @* begin
		case (frame_clock_divider)
		`LCDC_DIV_CODE_512: begin
			half_count = `LCDC_HALF_512;
		end
		`LCDC_DIV_CODE_256: begin
			half_count = `LCDC_HALF_256;
		end
		`LCDC_DIV_CODE_128: begin
			half_count = `LCDC_HALF_128;
		end
		`LCDC_DIV_CODE_64: begin
			half_count = `LCDC_HALF_64;
		end
		default: begin
			half_count = `LCDC_HALF_512;
		end
		endcase
	end

	// Frame divider. It is held cleared while the display is off so the
	// first frame after enable starts at common 0 with a full period.
	// Lowering the divider mid-period ends that half period at the next crystal tick if tick_cnt is already at or past the new half count minus one.
	reg [8:0] tick_cnt;
	wire half_done = xtal_tick && (tick_cnt >= half_count - 9'h001);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt <= 9'h000;
			frame_clock <= 1'b0;
			frame_tick <= 1'b0;
			com_slot <= 2'h0;
		end else if (!display_enable) begin
			tick_cnt <= 9'h000;
			frame_clock <= 1'b0;
			frame_tick <= 1'b0;
			com_slot <= 2'h0;
		end else if (half_done) begin
			tick_cnt <= 9'h000;
			frame_clock <= ~frame_clock;
			frame_tick <= frame_clock;
			if (frame_clock) begin
				com_slot <= com_slot + 2'h1;
			end
		end else begin
			if (xtal_tick) begin
				tick_cnt <= tick_cnt + 9'h001;
			end
			frame_tick <= 1'b0;
		end
	end

	// Blink gate for segment 18 in the current common time slot.
	// It lags com_slot by one cycle, which is far below a frame period.
	// The waveform generator decides what blinking looks like; this block
	// only tells it in which common slots segment 18 takes part.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			blink_active <= 1'b0;
		end else begin
			blink_active <= blink_mask_seg18[com_slot] & display_enable;
		end
	end

endmodule

// file: verification/lcdc_config_asserts.sv
// Port checker for the LCD segment drive configuration block.
`timescale 1ns/1ns
module lcdc_config_chk (
	// Clock, reset and bus handshake.
	input wire clk,
	input wire rst,
	input wire read,
	input wire write,
	input wire waitrequest,
	// Display drive.
	input wire [3:0] com_drive,
	input wire [3:0] com_out,
	input wire bias_rail_top,
	input wire bias_rail_mid,
	input wire bias_rail_low,
	input wire blink_active,
	input wire frame_clock,
	input wire frame_tick,
	input wire display_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_wait_ans;
		(read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
	endproperty
	a_wait_ans: assert property (p_wait_ans) else $error("bus answer");
	property p_wait_idle;
		!read && !write |=> waitrequest;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("bus idle");
	property p_rails_off;
		!display_enable && !$past(display_enable) |->
			!(bias_rail_top || bias_rail_mid || bias_rail_low);
	endproperty
	a_rails_off: assert property (p_rails_off) else $error("rails");
	property p_rails_on;
		display_enable && $past(display_enable) |->
			bias_rail_top && bias_rail_mid && bias_rail_low;
	endproperty
	a_rails_on: assert property (p_rails_on) else $error("rails on");
	property p_com;
		com_out == ($past(com_drive) & {4{$past(display_enable)}});
	endproperty
	a_com: assert property (p_com) else $error("com_out");
	property p_blink_off;
		!$past(display_enable) |-> !blink_active;
	endproperty
	a_blink_off: assert property (p_blink_off) else $error("blink");
	property p_tick_pulse;
		frame_tick |=> !frame_tick;
	endproperty
	a_tick_pulse: assert property (p_tick_pulse) else $error("tick");
	// A fall forced by switching the display off carries no frame tick.
	property p_tick_fall;
		$fell(frame_clock) && $past(display_enable) |-> frame_tick;
	endproperty
	a_tick_fall: assert property (p_tick_fall) else $error("fall");
endmodule
bind lcdc_config lcdc_config_chk u_chk (.clk, .rst, .read, .write,
	.waitrequest, .com_drive, .com_out, .bias_rail_top, .bias_rail_mid,
	.bias_rail_low, .blink_active, .frame_clock, .frame_tick,
	.display_enable);

// file: verification/tb_lcd_segment_drive_config.sv
// Self-checking bench for the LCD segment drive configuration block.
`timescale 1ns/1ns
`include "lcdc_consts.vh"
module tb_lcd_segment_drive_config;
	logic clk = 1'h0, rst = 1'h1, read = 1'h0, write = 1'h0;
	logic [15:0] address = 16'h0000;
	logic [31:0] writedata = 32'h0000_0000, readdata, q;
	logic [17:0] seg_drive = 18'h2_D4B3, general_io_out = 18'h1_5A5A;
	logic [17:0] general_io_oe = 18'h2_A5C3, pin_in = 18'h3_3CC3;
	logic [17:0] general_io_in, pin_out, pin_oe;
	logic [3:0] com_drive = 4'h6, com_out;
	logic [2:0] contrast_code;
	logic [1:0] com_slot;
	logic waitrequest, bias_rail_top, bias_rail_mid, bias_rail_low;
	logic frame_clock, frame_tick, blink_active, display_enable;
	int mismatches = 0, tests_run = 0;
	// A fast crystal rate keeps the slowest frame near two thousand cycles.
	lcdc_config #(.XTAL_HZ(26'h5F_5E10)) dut (.clk, .rst, .address, .read,
		.write, .writedata, .readdata, .waitrequest, .seg_drive, .com_drive,
		.general_io_out, .general_io_oe, .general_io_in, .pin_in, .pin_out,
		.pin_oe, .com_out, .bias_rail_top, .bias_rail_mid, .bias_rail_low,
		.frame_clock, .frame_tick, .com_slot, .blink_active, .contrast_code,
		.display_enable);
	initial forever #20 clk = ~clk;
	task report_and_stop;
		if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task check(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic wr, input logic [15:0] ix,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		read <= !wr;
		write <= wr;
		address <= {ix[13:0], 2'h0};
		writedata <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		if (waitrequest !== 1'b0) begin
			mismatches++;
			$display("MISMATCH waitrequest expected 0 seen %b", waitrequest);
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic t_regs;
		logic [15:0] ix[6];
		logic [7:0] m[6];
		int i;
		ix = '{`LCDC_IDX_CTRL, `LCDC_IDX_PSEL0, `LCDC_IDX_PSEL1,
			`LCDC_IDX_PSEL2, `LCDC_IDX_BLINK, `LCDC_IDX_DAC};
		m = '{8'h23, 8'h07, 8'hEF, 8'hFF, 8'h0F, 8'h0E};
		for (i = 0; i < 6; i++) begin
			bus(1'b0, ix[i], 32'h0000_0000);
			check("reset value", 32'h0000_0000, q);
			bus(1'b1, ix[i], 32'hFFFF_FFFF);
			bus(1'b0, ix[i], 32'h0000_0000);
			check("field mask", {24'h00_0000, m[i]}, q);
		end
		bus(1'b1, 16'h2000, 32'hFFFF_FFFF);
		bus(1'b0, 16'h2000, 32'h0000_0000);
		check("unmapped", 32'h0000_0000, q);
		for (i = 0; i < 8; i++) begin
			bus(1'b1, `LCDC_IDX_DAC, i << 1);
			repeat (2) @(negedge clk);
			check("contrast_code", i, contrast_code);
		end
	endtask
	task automatic t_pins(input logic en);
		logic [17:0] s;
		s = {8'h81, 3'b101, 4'h1, 3'b101};
		bus(1'b1, `LCDC_IDX_PSEL0, 32'h0000_0005);
		bus(1'b1, `LCDC_IDX_PSEL1, 32'h0000_00B1);
		bus(1'b1, `LCDC_IDX_PSEL2, 32'h0000_0081);
		bus(1'b1, `LCDC_IDX_CTRL, {26'h0, en, 5'h00});
		repeat (2) @(negedge clk);
		check("pin_oe", s | (general_io_oe & ~s), pin_oe);
		check("pin_out", (seg_drive & s & {18{en}}) |
			(general_io_out & ~s), pin_out);
		check("general_io_in", pin_in & ~s, general_io_in);
		check("rails", {3{en}}, {bias_rail_top, bias_rail_mid,
			bias_rail_low});
		check("com_out", com_drive & {4{en}}, com_out);
	endtask
	task automatic wait_tick(output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (frame_tick !== 1'b1 && n < 5000);
	endtask
	task automatic t_frame(input logic [1:0] c, input int half);
		int n, k;
		bus(1'b1, `LCDC_IDX_CTRL, {26'h0, 1'b1, 3'h0, c});
		bus(1'b1, `LCDC_IDX_BLINK, 32'h0000_0008);
		for (k = 0; k < 5; k++) begin
			wait_tick(n);
			if (k > 1) check("frame period", half * 8, n + 3);
			repeat (3) @(negedge clk);
			check("blink_active", com_slot === 2'h3, blink_active);
		end
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_pins(1'b0);
		t_pins(1'b1);
		t_frame(`LCDC_DIV_CODE_512, `LCDC_HALF_512);
		t_frame(`LCDC_DIV_CODE_256, `LCDC_HALF_256);
		t_frame(`LCDC_DIV_CODE_128, `LCDC_HALF_128);
		t_frame(`LCDC_DIV_CODE_64, `LCDC_HALF_64);
		report_and_stop;
	end
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		report_and_stop;
	end
endmodule
